// file: logic/phy_pin_logic.v
// Pin-level logic of the PHY: straps, MII/RMII pins, interrupt and link indicator
`include "phy_pin_map.vh"
`default_nettype none

module phy_pin_logic #(
    parameter [23:0] BLINK_CYCLES = `BLINK_CYC
) (
    input wire clock,
    input wire resetn,
    // Register port from the management logic
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Internal receive stream
    input wire rx_in_valid,
    output wire rx_in_ready,
    input wire [3:0] rx_in_data,
    input wire rx_in_err,
    input wire carrier_in,
    input wire collision_in,
    // Internal transmit stream
    output reg tx_out_valid,
    output reg [3:0] tx_out_data,
    // Status and events from the datapath
    input wire link_up,
    input wire activity,
    input wire [7:0] irq_events,
    // Straps as seen by the rest of the chip
    output wire [4:0] station_address,
    output wire [2:0] interface_mode,
    output wire detach_setting,
    // MAC-facing pins
    input wire ref_clk,
    output reg rx_clock_out,
    output reg tx_clock_out,
    input wire tx_en,
    input wire [3:0] txd,
    input wire [3:0] rxd_in,
    output reg [3:0] rxd_out,
    output reg [3:0] rxd_oe_n,
    input wire rx_dv_in,
    output reg carrier_valid_combined,
    output reg rx_dv_oe_n,
    input wire rx_er_in,
    output reg rx_er_out,
    output reg rx_er_oe_n,
    input wire col_in,
    output reg col_out,
    output reg col_oe_n,
    input wire crs_in,
    output reg crs_out,
    output reg crs_oe_n,
    input wire link_indicator_in,
    output reg link_indicator,
    output reg link_indicator_oe_n,
    output reg irq_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam [2:0] RX_IDLE = 3'h1;
    localparam [2:0] RX_SEND = 3'h2;
    localparam [2:0] RX_HIGH = 3'h4;

    wire [14:0] pins_s;
    wire ref_s;
    wire tx_en_s;
    wire [3:0] txd_s;
    wire [3:0] rxd_s;
    wire dv_s;
    wire er_s;
    wire col_s;
    wire crs_s;
    wire led_s;

    reg [3:0] addr_strap_q;
    reg [2:0] mode_q;
    reg duplex_q;
    reg detach_q;
    reg autoneg_q;
    reg [15:0] basic_q;
    reg [7:0] irq_en_q;
    reg [7:0] irq_stat_q;
    reg [1:0] led_mode_q;
    reg [15:0] aux_q;
    reg driving_q;

    reg [1:0] div_cnt_q;
    reg mii_clk_q;
    reg ref_prev_q;
    wire is_rmii;
    wire mii_rise;
    wire mii_fall;
    wire ref_rise;
    wire rx_event;
    wire tx_event;

    wire fifo_valid;
    wire fifo_ready;
    wire [4:0] fifo_data;
    reg [2:0] rx_state_q;
    reg [3:0] rx_word_q;
    reg [3:0] rx_nib_q;
    reg rx_dv_q;
    reg rx_err_q;
    reg tx_half_q;
    reg [1:0] tx_low_q;

    reg [23:0] blink_cnt_q;
    reg blink_q;
    reg act_pend_q;
    wire blink_wrap;
    wire stat_clear;
    wire irq_active;
    reg led_d;

    // Equality test of the combined mode field
    function is_mode;
        input [2:0] mode;
        input [2:0] want;
        begin
            is_mode = (mode == want);
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pin_sync #(.WIDTH(15)) u_pin_sync (
        .clock(clock),
        .async_in({ref_clk, tx_en, txd, rxd_in, rx_dv_in, rx_er_in, col_in, crs_in,
                   link_indicator_in}),
        .sync_out(pins_s)
    );

    assign ref_s = pins_s[14];
    assign tx_en_s = pins_s[13];
    assign txd_s = pins_s[12:9];
    assign rxd_s = pins_s[8:5];
    assign dv_s = pins_s[4];
    assign er_s = pins_s[3];
    assign col_s = pins_s[2];
    assign crs_s = pins_s[1];
    assign led_s = pins_s[0];

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    // Straps track the pins all through reset, the last value before release sticks
    always @(posedge clock) begin
        if (!resetn) begin
            addr_strap_q <= {rxd_s[1], rxd_s[2], rxd_s[3], 1'b0};
            mode_q <= {dv_s, crs_s, col_s};
            detach_q <= er_s;
            duplex_q <= rxd_s[0];
            autoneg_q <= led_s;
            driving_q <= 1'b0;
        end else begin
            driving_q <= 1'b1;
        end
    end

    // Address bits 4:3 are always zero
    assign station_address = {2'b00, addr_strap_q[3:1]};
    assign interface_mode = mode_q;
    assign detach_setting = basic_q[`BC_DETACH_SETTING_BIT];
    assign is_rmii = is_mode(mode_q, `MODE_RMII);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    assign stat_clear = reg_rd && (reg_addr == `REG_IRQ_CTRL_STATUS);

    // Control registers; strapped bits load on the first edge after release
    always @(posedge clock) begin
        if (!resetn) begin
            basic_q <= `BASIC_CONTROL_RST;
            irq_en_q <= `IRQ_ENABLE_RST;
            led_mode_q <= `INDICATOR_RST;
            aux_q <= `AUX_CONTROL_RST;
        end else if (!driving_q) begin
            basic_q[`BC_DUPLEX_BIT] <= duplex_q;
            basic_q[`BC_AUTONEG_BIT] <= autoneg_q;
            basic_q[`BC_DETACH_SETTING_BIT] <= detach_q;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_BASIC_CONTROL: basic_q <= reg_wdata;
                `REG_IRQ_CTRL_STATUS: irq_en_q <= reg_wdata[`IRQ_EN_HI:`IRQ_EN_LO];
                `REG_INDICATOR_CONTROL: led_mode_q <= reg_wdata[`IND_MODE_HI:`IND_MODE_LO];
                `REG_AUX_CONTROL: aux_q <= reg_wdata;
                default: basic_q <= basic_q;
            endcase
        end
    end

    // Sticky status; an event in the clearing cycle survives
    always @(posedge clock) begin
        if (!resetn) begin
            irq_stat_q <= 8'h00;
        end else begin
            irq_stat_q <= (irq_stat_q & {8{~stat_clear}}) | irq_events;
        end
    end

    // Read data, unmapped offsets read zero
    always @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_BASIC_CONTROL: reg_rdata <= basic_q;
                `REG_IRQ_CTRL_STATUS: reg_rdata <= {irq_en_q, irq_stat_q};
                `REG_INDICATOR_CONTROL: reg_rdata <= {led_mode_q, 14'h0000};
                `REG_AUX_CONTROL: reg_rdata <= aux_q;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    assign irq_active = |(irq_stat_q & irq_en_q);

    // Inactive level after reset is high, matching the default polarity
    always @(posedge clock) begin
        if (!resetn) begin
            irq_out <= 1'b1;
        end else begin
            irq_out <= aux_q[`AUX_IRQ_POL_BIT] ? irq_active : ~irq_active;
        end
    end

    // ----------------------------------------
    // Link clocks
    // ----------------------------------------
    // 25 MHz MII clock from the 200 MHz core clock
    always @(posedge clock) begin
        if (!resetn) begin
            div_cnt_q <= 2'h0;
            mii_clk_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
            if (div_cnt_q == `MII_DIV_LAST) begin
                div_cnt_q <= 2'h0;
                mii_clk_q <= ~mii_clk_q;
            end else begin
                div_cnt_q <= div_cnt_q + 2'h1;
            end
        end
    end

    assign mii_rise = (div_cnt_q == `MII_DIV_LAST) && !mii_clk_q;
    assign mii_fall = (div_cnt_q == `MII_DIV_LAST) && mii_clk_q;
    assign ref_rise = ref_s && !ref_prev_q;
    // MII launches on the falling edge so the MAC sees stable data at the rise
    assign rx_event = is_rmii ? ref_rise : mii_fall;
    assign tx_event = is_rmii ? ref_rise : mii_rise;

    // Clocks only leave the chip in MII mode and when attached
    always @(posedge clock) begin
        if (!resetn) begin
            rx_clock_out <= 1'b0;
            tx_clock_out <= 1'b0;
        end else begin
            rx_clock_out <= mii_clk_q && !is_rmii && !detach_setting;
            tx_clock_out <= mii_clk_q && !is_rmii && !detach_setting;
        end
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    word_fifo #(.WIDTH(5), .DEPTH(8), .AW(3)) u_rx_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data({rx_in_err, rx_in_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // Pop one nibble per link edge, except while the high dibit is still pending
    assign fifo_ready = rx_event && driving_q && (rx_state_q != RX_HIGH);

    // Serialiser: whole nibbles in MII, two dibits per nibble in RMII
    always @(posedge clock) begin
        if (!resetn) begin
            rx_state_q <= RX_IDLE;
            rx_word_q <= 4'h0;
            rx_nib_q <= 4'h0;
            rx_dv_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else if (rx_event) begin
            case (rx_state_q)
                RX_HIGH: begin
                    rx_nib_q <= {2'b00, rx_word_q[3:2]};
                    rx_state_q <= RX_SEND;
                end
                RX_IDLE, RX_SEND: begin
                    if (fifo_valid && driving_q) begin
                        rx_word_q <= fifo_data[3:0];
                        rx_err_q <= fifo_data[4];
                        rx_dv_q <= 1'b1;
                        if (is_rmii) begin
                            rx_nib_q <= {2'b00, fifo_data[1:0]};
                            rx_state_q <= RX_HIGH;
                        end else begin
                            rx_nib_q <= fifo_data[3:0];
                            rx_state_q <= RX_SEND;
                        end
                    end else begin
                        rx_dv_q <= 1'b0;
                        rx_err_q <= 1'b0;
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Pin drivers; released during reset so straps can be read
    always @(posedge clock) begin
        if (!resetn) begin
            rxd_out <= 4'h0;
            rxd_oe_n <= 4'hf;
            carrier_valid_combined <= 1'b0;
            rx_dv_oe_n <= 1'b1;
            rx_er_out <= 1'b0;
            rx_er_oe_n <= 1'b1;
            col_out <= 1'b0;
            col_oe_n <= 1'b1;
            crs_out <= 1'b0;
            crs_oe_n <= 1'b1;
        end else begin
            rxd_out <= rx_nib_q;
            rxd_oe_n <= detach_setting ? 4'hf : (is_rmii ? 4'hc : 4'h0);
            carrier_valid_combined <= is_rmii ? (carrier_in || rx_dv_q) : rx_dv_q;
            rx_dv_oe_n <= detach_setting;
            rx_er_out <= rx_err_q;
            rx_er_oe_n <= detach_setting;
            col_out <= collision_in;
            col_oe_n <= detach_setting || is_rmii;
            crs_out <= carrier_in;
            crs_oe_n <= detach_setting || is_rmii;
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    // Nibble per edge in MII, dibit pairs in RMII, low dibit first
    always @(posedge clock) begin
        if (!resetn) begin
            tx_out_valid <= 1'b0;
            tx_out_data <= 4'h0;
            tx_half_q <= 1'b0;
            tx_low_q <= 2'h0;
        end else begin
            tx_out_valid <= 1'b0;
            if (tx_event && driving_q) begin
                if (!tx_en_s) begin
                    tx_half_q <= 1'b0;
                end else if (!is_rmii) begin
                    tx_out_valid <= 1'b1;
                    tx_out_data <= txd_s;
                end else if (!tx_half_q) begin
                    tx_low_q <= txd_s[1:0];
                    tx_half_q <= 1'b1;
                end else begin
                    tx_out_valid <= 1'b1;
                    tx_out_data <= {txd_s[1:0], tx_low_q};
                    tx_half_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Link indicator
    // ----------------------------------------
    assign blink_wrap = (blink_cnt_q == (BLINK_CYCLES - 24'h00_0001));

    // Activity is remembered until the next blink slot; a new one beats the clear
    always @(posedge clock) begin
        if (!resetn) begin
            blink_cnt_q <= 24'h00_0000;
            blink_q <= 1'b0;
            act_pend_q <= 1'b0;
        end else begin
            blink_cnt_q <= blink_wrap ? 24'h00_0000 : blink_cnt_q + 24'h00_0001;
            if (blink_wrap) begin
                blink_q <= act_pend_q ? ~blink_q : 1'b0;
                act_pend_q <= activity;
            end else if (activity) begin
                act_pend_q <= 1'b1;
            end
        end
    end

    // Reserved modes leave the indicator off
    always @* begin
        case (led_mode_q)
            `LED_LINK_ACT: led_d = link_up ? blink_q : 1'b1;
            `LED_LINK_ONLY: led_d = ~link_up;
            default: led_d = 1'b1;
        endcase
    end

    always @(posedge clock) begin
        if (!resetn) begin
            link_indicator <= 1'b1;
            link_indicator_oe_n <= 1'b1;
        end else begin
            link_indicator <= led_d;
            link_indicator_oe_n <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: logic/phy_pin_map.vh
// Register offsets, field positions, reset values and timing counts of the pin logic
`ifndef PHY_PIN_MAP_VH
`define PHY_PIN_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_BASIC_CONTROL 5'h00
`define REG_IRQ_CTRL_STATUS 5'h1b
`define REG_INDICATOR_CONTROL 5'h1e
`define REG_AUX_CONTROL 5'h1f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BC_DUPLEX_BIT 8
`define BC_DETACH_SETTING_BIT 10
`define BC_AUTONEG_BIT 12
`define IND_MODE_HI 15
`define IND_MODE_LO 14
`define AUX_IRQ_POL_BIT 9
`define IRQ_EN_HI 15
`define IRQ_EN_LO 8

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define BASIC_CONTROL_RST 16'h0000
`define IRQ_ENABLE_RST 8'h00
`define INDICATOR_RST 2'h0
`define AUX_CONTROL_RST 16'h0000
`define MODE_MII 3'h0
`define MODE_RMII 3'h1
`define LED_LINK_ACT 2'h0
`define LED_LINK_ONLY 2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_NS 5
`define MII_CLK_NS 40
`define MII_DIV_LAST 2'h3
`define BLINK_NS 50000000
`define BLINK_CYC 24'h98_9680

`endif

// file: logic/pin_sync.v
// Two-flop synchroniser for a group of pins from outside the clock domain
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // No reset: straps must pass through while reset is still held
    always @(posedge clock) begin
        meta_q <= async_in;
        stable_q <= meta_q;
    end

    assign sync_out = stable_q;

endmodule

`default_nettype wire

// file: logic/word_fifo.v
// Synchronous FIFO with valid/ready on both sides
`default_nettype none

module word_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clock,
    input wire resetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_q;
    reg [AW:0] rd_ptr_q;
    wire full;
    wire empty;
    wire push;
    wire pop;

    // Extra pointer bit tells full from empty
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;
    assign out_data = mem[rd_ptr_q[AW-1:0]];

    // Storage array, no reset needed
    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always @(posedge clock) begin
        if (!resetn) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// file: dv/phy_pins_sva.sv
// Checker for the pin logic top ports
`default_nettype none
module phy_pins_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [4:0] station_address,
    input wire logic [2:0] interface_mode,
    input wire logic detach_setting,
    input wire logic [3:0] rxd_oe_n,
    input wire logic [3:0] rxd_in,
    input wire logic rx_dv_oe_n,
    input wire logic col_oe_n,
    input wire logic crs_oe_n,
    input wire logic rx_clock_out,
    input wire logic tx_clock_out,
    input wire logic tx_en,
    input wire logic tx_out_valid,
    input wire logic link_up,
    input wire logic link_indicator,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Mode helpers
    // ----------------------------------------
    wire logic rmii = interface_mode == 3'h1;
    wire logic mii_on = !rmii && !detach_setting;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    reset_quiet_a: assert property (disable iff (1'b0) !resetn |=> irq_out && &rxd_oe_n)
        else $error("outputs not quiet in reset");
    addr_strap_a: assert property ($rose(resetn) |-> station_address == {2'b00,
        $past(rxd_in[1], 2), $past(rxd_in[2], 2), $past(rxd_in[3], 2)})
        else $error("address strap not captured");
    strap_hold_a: assert property ($past(resetn) |-> $stable(interface_mode)
        && $stable(station_address)) else $error("straps moved after reset");
    detach_pins_a: assert property (detach_setting && $past(detach_setting)
        |-> &rxd_oe_n && rx_dv_oe_n && col_oe_n && crs_oe_n) else $error("detached pins driven");
    rmii_pins_a: assert property (rmii && $past(resetn) |-> col_oe_n && crs_oe_n
        && &rxd_oe_n[3:2]) else $error("mii-only pins driven in rmii");
    mii_clock_a: assert property (mii_on [*8] |-> ##[0:4] ($changed(rx_clock_out)
        && $changed(tx_clock_out))) else $error("mii clocks stalled");
    rmii_clock_a: assert property (rmii && $past(resetn) |-> !rx_clock_out && !tx_clock_out)
        else $error("mii clocks running in rmii");
    tx_quiet_a: assert property (!tx_en [*8] |-> !tx_out_valid)
        else $error("transmit word without enable");
    led_nolink_a: assert property ((!link_up && !detach_setting) [*3] |-> link_indicator)
        else $error("indicator lit without link");
    cover property (rmii && tx_out_valid);
    cover property (!rmii && tx_out_valid);
    cover property (!irq_out);
endmodule
bind phy_pin_logic phy_pins_sva chk (.*);
`default_nettype wire

// file: dv/mac_model.sv
// Behavioural MAC on the far side of the MII/RMII pins
`default_nettype none
module mac_model (
    input wire logic tx_clock_out,
    input wire logic carrier_valid_combined,
    input wire logic [1:0] rx_dibit,
    output logic ref_clk,
    output logic tx_en,
    output logic [3:0] txd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] tx_q[$];
    logic [1:0] rx_q[$];
    initial begin
        ref_clk = 1'b0;
        tx_en = 1'b0;
        txd = 4'h0;
    end
    // MII nibble launched on the falling clock so it is settled at the rise
    task automatic mii_send(input logic [3:0] d);
        @(negedge tx_clock_out);
        tx_en <= 1'b1;
        txd <= d;
        @(negedge tx_clock_out);
        tx_en <= 1'b0;
        txd <= ~d;
    endtask
    // Reference clock stands still outside frames
    task automatic frame(input int n);
        repeat (n) begin
            #32 ref_clk = 1'b1;
            #32 ref_clk = 1'b0;
        end
    endtask
    // One dibit per reference period while enable is up
    always @(negedge ref_clk) begin
        tx_en = tx_q.size() != 0;
        if (tx_en)
            txd = {2'b00, tx_q.pop_front()};
    end
    // Dibits taken only while carrier/valid is up
    always @(posedge ref_clk) begin
        if (carrier_valid_combined)
            rx_q.push_back(rx_dibit);
    end
endmodule
`default_nettype wire

// file: dv/phy_pin_strap_led_irq_logic_test.sv
// Self-checking bench for the PHY pin logic
`default_nettype none
`include "phy_pin_map.vh"
module phy_pin_strap_led_irq_logic_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic rx_in_valid = 1'b0;
    logic rx_in_err = 1'b0;
    logic carrier_in = 1'b0;
    logic collision_in = 1'b0;
    logic link_up = 1'b0;
    logic activity = 1'b0;
    logic [3:0] rx_in_data = 4'h0;
    logic [7:0] irq_events = 8'h00;
    logic [3:0] tx_out_data, txd, rxd_in, rxd_out, rxd_oe_n, s_rxd, tx_seen;
    logic [4:0] station_address;
    logic [2:0] interface_mode;
    logic rx_in_ready, tx_out_valid, detach_setting, ref_clk, rx_clock_out, tx_clock_out, tx_en;
    logic rx_dv_in, carrier_valid_combined, rx_dv_oe_n, rx_er_in, rx_er_out, rx_er_oe_n;
    logic col_in, col_out, col_oe_n, crs_in, crs_out, crs_oe_n, irq_out;
    logic link_indicator_in, link_indicator, link_indicator_oe_n;
    logic s_dv, s_er, s_col, s_crs, s_led;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_tx = 0;
    // Released pins fall back to their strap pull level
    assign rxd_in = (rxd_oe_n & s_rxd) | (~rxd_oe_n & rxd_out);
    assign rx_dv_in = rx_dv_oe_n ? s_dv : carrier_valid_combined;
    assign rx_er_in = rx_er_oe_n ? s_er : rx_er_out;
    assign col_in = col_oe_n ? s_col : col_out;
    assign crs_in = crs_oe_n ? s_crs : crs_out;
    assign link_indicator_in = link_indicator_oe_n ? s_led : link_indicator;
    // Short blink slot keeps the run brief
    phy_pin_logic #(.BLINK_CYCLES(24'h10)) uut (.*);
    mac_model mac (.tx_clock_out(tx_clock_out), .carrier_valid_combined(carrier_valid_combined),
        .rx_dibit(rxd_out[1:0]), .ref_clk(ref_clk), .tx_en(tx_en), .txd(txd));
    always #2.5 clock = ~clock;
    // Transmit words and a ceiling against hangs
    always @(posedge clock) begin
        cycles++;
        if (tx_out_valid) begin
            tx_seen <= tx_out_data;
            n_tx <= n_tx + 1;
        end
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd_chk(input string w, input logic [4:0] a, input logic [15:0] e);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk(w, e, reg_rdata);
    endtask
    // Strap levels {rxd, valid, error, collision, carrier, led} held over reset
    task automatic t_straps(input logic [8:0] s, input logic [4:0] a, input logic [2:0] m,
        input logic [15:0] b, input logic d);
        @(negedge clock);
        {s_rxd, s_dv, s_er, s_col, s_crs, s_led} = s;
        resetn = 1'b0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        chk("address", a, station_address);
        chk("mode", m, interface_mode);
        chk("detach", d, detach_setting);
        rd_chk("control", `REG_BASIC_CONTROL, b);
        $display("test straps %h done", s);
    endtask
    task automatic t_mii;
        int n;
        t_straps(9'h061, 5'h04, 3'h0, 16'h1100, 1'b0);
        n = n_tx;
        mac.mii_send(4'ha);
        repeat (20) @(negedge clock);
        chk("tx count", n + 1, n_tx);
        chk("tx nibble", 4'ha, tx_seen);
        rx_in_data = 4'h5;
        rx_in_err = 1'b1;
        rx_in_valid = 1'b1;
        @(negedge clock);
        rx_in_valid = 1'b0;
        n = 0;
        while (carrier_valid_combined !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk("rx nibble", 4'h5, rxd_out);
        chk("rx error", 1'b1, rx_er_out);
        chk("rx pins", 4'h0, rxd_oe_n);
        rx_in_err = 1'b0;
        carrier_in = 1'b1;
        collision_in = 1'b1;
        repeat (2) @(negedge clock);
        chk("carrier pin", 2'b01, {crs_oe_n, crs_out});
        chk("collision pin", 2'b01, {col_oe_n, col_out});
        carrier_in = 1'b0;
        collision_in = 1'b0;
        $display("test mii done");
    endtask
    task automatic t_regs;
        logic v;
        rd_chk("led mode", `REG_INDICATOR_CONTROL, 16'h0000);
        wr(`REG_INDICATOR_CONTROL, 16'h4000);
        rd_chk("led mode", `REG_INDICATOR_CONTROL, 16'h4000);
        link_up = 1'b1;
        repeat (4) @(negedge clock);
        chk("led linked", 1'b0, link_indicator);
        wr(`REG_INDICATOR_CONTROL, 16'h0000);
        activity = 1'b1;
        repeat (20) @(negedge clock);
        v = link_indicator;
        repeat (16) @(negedge clock);
        chk("led blink", !v, link_indicator);
        activity = 1'b0;
        link_up = 1'b0;
        rd_chk("unmapped", 5'h05, 16'h0000);
        wr(`REG_IRQ_CTRL_STATUS, 16'h0100);
        irq_events = 8'h02;
        @(negedge clock);
        irq_events = 8'h00;
        repeat (2) @(negedge clock);
        chk("irq masked", 1'b1, irq_out);
        irq_events = 8'h01;
        @(negedge clock);
        irq_events = 8'h00;
        repeat (2) @(negedge clock);
        chk("irq raised", 1'b0, irq_out);
        rd_chk("irq status", `REG_IRQ_CTRL_STATUS, 16'h0103);
        repeat (2) @(negedge clock);
        chk("irq cleared", 1'b1, irq_out);
        wr(`REG_AUX_CONTROL, 16'h0200);
        repeat (2) @(negedge clock);
        chk("irq high idle", 1'b0, irq_out);
        $display("test regs done");
    endtask
    task automatic t_rmii;
        t_straps(9'h004, 5'h00, 3'h1, 16'h0000, 1'b0);
        rx_in_valid = 1'b1;
        for (int i = 0; i < 9; i++) begin
            rx_in_data = 4'(i + 9);
            @(negedge clock);
        end
        rx_in_valid = 1'b0;
        chk("fifo full", 1'b0, rx_in_ready);
        mac.tx_q = '{2'b10, 2'b01};
        mac.frame(24);
        chk("rmii tx", 4'h6, tx_seen);
        chk("dibits", 16'h0010, mac.rx_q.size());
        chk("first nibble", 4'h9, {mac.rx_q[1], mac.rx_q[0]});
        chk("last nibble", 4'h0, {mac.rx_q[15], mac.rx_q[14]});
        chk("fifo drained", 1'b1, rx_in_ready);
        carrier_in = 1'b1;
        repeat (2) @(negedge clock);
        chk("carrier valid", 1'b1, carrier_valid_combined);
        carrier_in = 1'b0;
        chk("collision off", 1'b1, col_oe_n);
        $display("test rmii done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {s_rxd, s_dv, s_er, s_col, s_crs, s_led} = 9'h000;
        repeat (2) @(negedge clock);
        t_straps(9'h09a, 5'h02, 3'h6, 16'h0400, 1'b1);
        chk("detached rxd", 4'hf, rxd_oe_n);
        t_mii();
        t_regs();
        t_rmii();
        stop_test();
    end
endmodule
`default_nettype wire
